/* wdtim_pkg.sv */
// shared constants and the expiry helper function for the watchdog timer and its cpu-side end
package wdtim_pkg;
  // control/status register bit positions
  localparam int BIT_FLAG = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_PER3 = 5;
  localparam int BIT_UNLOCK = 4;
  localparam int BIT_RST_EN = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // unlock window in system clocks
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // period codes: 0 selects 2048 oscillator cycles, each step doubles
  localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
  localparam int BASE_SHIFT = 11;
  localparam int CNT_W = 21;
  // controller register offsets (port of the cpu-side end)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CAUSE = 4'h1;
  localparam logic [3:0] OFS_CMD = 4'h2;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h4;
  localparam logic [3:0] OFS_IRQ_EN = 4'h5;
  // command register bits
  localparam int CMD_RESTART = 0;
  localparam int CMD_VECTOR = 1;
  localparam int CMD_GIE = 2;
  localparam int CMD_FUSE = 3;
  // interrupt status bits of the controller
  localparam int EV_TIMEOUT = 0;
  localparam int EV_SYSRST = 1;
  localparam int EV_W = 2;
  // expiry count for a period code
  function automatic logic [CNT_W-1:0] expiry_count(input logic [3:0] code);
    logic [CNT_W-1:0] one;
    one = {{(CNT_W-1){1'b0}}, 1'b1};
    expiry_count = one << (BASE_SHIFT + int'(code));
  endfunction
endpackage

/* wdtim_if.sv */
// link between the watchdog and the cpu/reset side
`timescale 1ns/100ps
`default_nettype none
interface wdtim_if;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic restart;
  logic vector_taken;
  logic gie;
  logic fuse;
  logic cause_clear;
  logic irq_req;
  logic sys_reset;
  logic cause_flag;
  logic osc_tick;
  modport dev (input wr, wdata, restart, vector_taken, gie, fuse,
    cause_clear, osc_tick, output rdata, irq_req, sys_reset, cause_flag);
  modport cpu (output wr, wdata, restart, vector_taken, gie, fuse,
    cause_clear, osc_tick, input rdata, irq_req, sys_reset, cause_flag);
endinterface
`default_nettype wire

/* wdtim_dev.sv */
// watchdog timer device end: counter, modes, unlock, reset cause
// Function
// RULE1 - expiry in interrupt mode sets flag bit 7
// RULE2 - vector execution or writing one clears flag
// RULE3 - request only when flag, enable, global set
// RULE4 - irq enable without reset enable: interrupts only
// RULE5 - combined mode first expiry only interrupts
// RULE6 - vector in combined mode clears enable, flag
// RULE7 - unserviced combined interrupt, next expiry resets
// RULE8 - software re-arms irq enable outside handler
// RULE9 - clear reset enable, period only when unlocked
// RULE10 - unlock bit self-clears after four clocks
// RULE11 - reset cause flag forces reset enable
// RULE12 - software clears cause flag before reset enable
// RULE13 - period code selects 2048 doubling to 1048576
// RULE14 - software restarts count before period change
// RULE15 - counts oscillator ticks, restart instruction zeroes
// RULE16 - fuse forces reset-only mode
// RULE17 - unlock: write unlock plus reset enable, then value
// RULE18 - watchdog reset sets cause flag until cleared
// RULE19 - both enables clear: stopped, no action
`timescale 1ns/100ps
`default_nettype none
module wdtim_dev
  import wdtim_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  wdtim_if.dev LINK
);
  import wdtim_pkg::*;

  logic flag;
  logic irq_en;
  logic rst_en;
  logic [3:0] period;
  logic unlock;
  logic [2:0] unlock_cnt;
  logic cause;
  logic [CNT_W-1:0] count;
  logic tick_s1;
  logic tick_s2;
  logic tick_s3;
  logic tick;
  logic expire;
  logic eff_rst_en;
  logic eff_irq_en;
  logic [3:0] wr_period;
  logic rst_pulse;

  // oscillator tick is asynchronous: two flops, then edge detect
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_s3 <= 1'b0;
    end else begin
      tick_s1 <= LINK.osc_tick;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
    end
  end
  assign tick = tick_s2 & ~tick_s3;

  // effective mode bits after fuse and cause override
  assign eff_rst_en = rst_en | cause | LINK.fuse; // RULE11 RULE16
  assign eff_irq_en = irq_en & ~LINK.fuse; // RULE16
  assign wr_period = {LINK.wdata[BIT_PER3], LINK.wdata[2:0]};
  // reserved codes never expire, count just saturates
  assign expire = tick && (period <= PERIOD_MAX_CODE)
    && (count + 1'b1 >= expiry_count(period)); // RULE13

  // counter: free while not stopped, zeroed by restart
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      count <= '0;
    end else if (LINK.restart || expire) begin
      count <= '0; // RULE15
    end else if (tick && (eff_rst_en || eff_irq_en)
        && count != {CNT_W{1'b1}}) begin
      count <= count + 1'b1; // RULE15 RULE19
    end
  end

  // unlock bit: set by write, dropped four clocks later
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      unlock <= 1'b0;
      unlock_cnt <= '0;
    end else if (LINK.wr && LINK.wdata[BIT_UNLOCK]) begin
      unlock <= 1'b1;
      unlock_cnt <= UNLOCK_CYCLES;
    end else if (unlock) begin
      unlock_cnt <= unlock_cnt - 1'b1;
      if (unlock_cnt == 3'h1) begin
        unlock <= 1'b0; // RULE10
      end
    end
  end

  // reset enable and period, guarded by the unlock window
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rst_en <= 1'b0;
      period <= '0;
    end else if (LINK.wr) begin
      if (LINK.wdata[BIT_RST_EN]) begin
        rst_en <= 1'b1; // setting is always allowed
      end else if (unlock && !LINK.wdata[BIT_UNLOCK]) begin
        rst_en <= 1'b0; // RULE9
      end
      if (unlock && !LINK.wdata[BIT_UNLOCK]) begin
        period <= wr_period; // RULE9
      end
    end
  end

  // irq enable: software write, hardware clear on combined vector
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      irq_en <= 1'b0;
    end else if (LINK.wr) begin
      irq_en <= LINK.wdata[BIT_IRQ_EN]; // RULE8
    end else if (LINK.vector_taken && eff_rst_en) begin
      irq_en <= 1'b0; // RULE6
    end
  end

  // time-out flag: expiry set wins over any clear
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      flag <= 1'b0;
    end else if (expire && eff_irq_en && !(eff_rst_en && flag)) begin
      flag <= 1'b1; // RULE1 RULE4 RULE5
    end else if (LINK.vector_taken) begin
      flag <= 1'b0; // RULE2 RULE6
    end else if (LINK.wr && LINK.wdata[BIT_FLAG]) begin
      flag <= 1'b0; // RULE2
    end
  end

  // reset only when not armed for a first-interrupt grace
  assign rst_pulse = expire && eff_rst_en
    && (!eff_irq_en || flag); // RULE4 RULE7 RULE16

  // system reset strobe and the cause flag it leaves behind
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      LINK.sys_reset <= 1'b0;
      cause <= 1'b0;
    end else begin
      LINK.sys_reset <= rst_pulse;
      if (rst_pulse) begin
        cause <= 1'b1; // RULE18
      end else if (LINK.cause_clear) begin
        cause <= 1'b0; // RULE12
      end
    end
  end

  // registered read image and interrupt request
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      LINK.rdata <= CTRL_RESET;
      LINK.irq_req <= 1'b0;
      LINK.cause_flag <= 1'b0;
    end else begin
      LINK.rdata <= {flag, eff_irq_en, period[3], unlock, eff_rst_en,
        period[2:0]}; // RULE11
      LINK.irq_req <= flag && eff_irq_en && LINK.gie
        && !LINK.vector_taken; // RULE3
      LINK.cause_flag <= cause;
    end
  end
endmodule // wdtim_dev
`default_nettype wire

/* wdtim_cpu.sv */
// cpu-side end: software registers driving the watchdog link
`timescale 1ns/100ps
`default_nettype none
module wdtim_cpu
  import wdtim_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic OSC_CLK,
  output logic [7:0] RDATA,
  output logic IRQ,
  wdtim_if.cpu LINK
);
  import wdtim_pkg::*;

  logic [EV_W-1:0] ev_stat;
  logic [EV_W-1:0] ev_en;
  logic [EV_W-1:0] ev_set;
  logic gie;
  logic fuse;
  logic [7:0] next_rdata;

  // one-cycle strobes toward the device from register writes
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      LINK.wr <= 1'b0;
      LINK.wdata <= '0;
      LINK.restart <= 1'b0;
      LINK.vector_taken <= 1'b0;
      LINK.cause_clear <= 1'b0;
    end else begin
      LINK.wr <= WR && ADDR == OFS_CTRL;
      LINK.wdata <= WDATA;
      LINK.restart <= WR && ADDR == OFS_CMD && WDATA[CMD_RESTART];
      LINK.vector_taken <= WR && ADDR == OFS_CMD && WDATA[CMD_VECTOR];
      // writing zero to the cause bit clears it
      LINK.cause_clear <= WR && ADDR == OFS_CAUSE && !WDATA[0]; // RULE12
    end
  end

  // global enable and fuse level are held settings
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      gie <= 1'b0;
      fuse <= 1'b0;
    end else if (WR && ADDR == OFS_CMD) begin
      gie <= WDATA[CMD_GIE];
      fuse <= WDATA[CMD_FUSE];
    end
  end
  assign LINK.gie = gie;
  assign LINK.fuse = fuse;
  // oscillator is just forwarded; the device synchronises it
  assign LINK.osc_tick = OSC_CLK;

  // sticky events: set beats clear
  assign ev_set = {LINK.sys_reset, LINK.irq_req};
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ev_stat <= '0;
      ev_en <= '0;
    end else begin
      if (WR && ADDR == OFS_IRQ_CLR) begin
        ev_stat <= (ev_stat & ~WDATA[EV_W-1:0]) | ev_set;
      end else begin
        ev_stat <= ev_stat | ev_set;
      end
      if (WR && ADDR == OFS_IRQ_EN) begin
        ev_en <= WDATA[EV_W-1:0];
      end
    end
  end

  // read mux, data appear the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    unique case (ADDR)
      OFS_CTRL: next_rdata = LINK.rdata;
      OFS_CAUSE: next_rdata = {7'h00, LINK.cause_flag};
      OFS_CMD: next_rdata = {4'h0, fuse, gie, 2'h0};
      OFS_IRQ_STAT: next_rdata = {6'h00, ev_stat};
      OFS_IRQ_EN: next_rdata = {6'h00, ev_en};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 8'h00;
      IRQ <= 1'b0;
    end else begin
      RDATA <= RD ? next_rdata : 8'h00;
      IRQ <= |(ev_stat & ev_en);
    end
  end
endmodule // wdtim_cpu
`default_nettype wire

/* wdtim_sva.sv */
// link assertions for the watchdog pair
`timescale 1ns/100ps
`default_nettype none
module wdtim_sva (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic vector_taken,
  input wire logic gie,
  input wire logic fuse,
  input wire logic irq_req,
  input wire logic sys_reset,
  input wire logic cause_flag
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // two-cycle settle allows for the registered image
  // a write or vector in the last cycle may have just cleared the flag
  property p_req;
    (rdata[7] && rdata[6] && gie && !wr && !vector_taken && !fuse)[*2]
    |=> irq_req;
  endproperty
  a_req: assert property (p_req) else $error("no irq");
  property p_fuse; fuse[*3] |-> rdata[3] && !rdata[6]; endproperty
  a_fuse: assert property (p_fuse) else $error("fuse");
  property p_cause; cause_flag[*3] |-> rdata[3]; endproperty
  a_cause: assert property (p_cause) else $error("cause");
  property p_unl; $rose(rdata[4]) |-> rdata[4][*4] ##1 !rdata[4];
  endproperty
  a_unl: assert property (p_unl) else $error("unlock");
  // a locked write must leave reset enable and period alone
  property p_lock; wr && !wdata[4] && !wdata[3] && rdata[3] && !rdata[4]
    && !$past(rdata[4]) |-> ##2 rdata[3] && rdata[2:0] == $past(rdata[2:0], 2);
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_rst; sys_reset |-> ##[1:2] cause_flag; endproperty
  a_rst: assert property (p_rst) else $error("cause");
  property p_norst; (!rdata[3] && !fuse && !cause_flag)[*2] |=> !sys_reset;
  endproperty
  a_norst: assert property (p_norst) else $error("rst");
  property p_vec; vector_taken && !wr && rdata[6] && rdata[3]
    |-> ##[1:3] !rdata[7] && !rdata[6]; endproperty
  a_vec: assert property (p_vec) else $error("vector");
endmodule // wdtim_sva
`default_nettype wire

/* watchdog_timer_with_interrupt_mode_test.sv */
// self-checking bench for the watchdog pair
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_with_interrupt_mode_test;
  import wdtim_pkg::*;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, osc = 0, irq;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  int n_errors = 0, n_tests = 0, cyc = 0;
  // rows: offset, write data, read back
  logic [19:0] rows [6] = '{20'h04040, 20'h00808, 20'h00008, 20'h00108,
    20'h50303, 20'hf5500};
  wdtim_if link ();
  wdtim_dev wdtim_dev_i (.CLK_SYS(clk), .NRST(nrst), .LINK(link));
  wdtim_cpu wdtim_cpu_i (.CLK_SYS(clk), .NRST(nrst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .OSC_CLK(osc), .RDATA(rdata),
    .IRQ(irq), .LINK(link));
  wdtim_sva wdtim_sva_i (.CLK_SYS(clk), .NRST(nrst), .wr(link.wr),
    .wdata(link.wdata), .rdata(link.rdata), .vector_taken(link.vector_taken),
    .gie(link.gie), .fuse(link.fuse), .irq_req(link.irq_req),
    .sys_reset(link.sys_reset), .cause_flag(link.cause_flag));
  always #12.5 clk = ~clk;
  // fast oscillator, off the clock grid, keeps expiry waits short
  always #51.3 osc = ~osc;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      n_errors++;
    end
  endtask
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // idle cycles first so the image settles and an unlock window has shut
  task automatic chk(input logic [3:0] a, input logic [7:0] e);
    repeat (5) @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      put(rows[i][19:16], rows[i][15:8]);
      chk(rows[i][19:16], rows[i][7:0]);
    end
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    chk(OFS_CTRL, CTRL_RESET);
    chk(OFS_IRQ_EN, 8'h00);
    // interrupt mode with a changed period
    put(OFS_IRQ_EN, 8'h03);
    put(OFS_CTRL, 8'h18);
    put(OFS_CTRL, 8'h41);
    chk(OFS_CTRL, 8'h41);
    put(OFS_CMD, 8'h05);
    repeat (16300) @(posedge clk);
    chk(OFS_CTRL, 8'h41);
    repeat (900) @(posedge clk);
    chk(OFS_CTRL, 8'hc1);
    cmp({7'h00, irq}, 8'h01);
    chk(OFS_IRQ_STAT, 8'h01);
    put(OFS_IRQ_EN, 8'h00);
    repeat (3) @(posedge clk);
    cmp({7'h00, irq}, 8'h00);
    put(OFS_IRQ_EN, 8'h03);
    // flag must drop first, the level request would re-set the status
    put(OFS_CTRL, 8'hc1);
    chk(OFS_CTRL, 8'h41);
    put(OFS_IRQ_CLR, 8'h03);
    chk(OFS_IRQ_STAT, 8'h00);
    // combined mode, first expiry then an unserviced second one
    put(OFS_CTRL, 8'h49);
    put(OFS_CMD, 8'h05);
    repeat (17200) @(posedge clk);
    chk(OFS_CTRL, 8'hc9);
    chk(OFS_IRQ_STAT, 8'h01);
    repeat (16800) @(posedge clk);
    chk(OFS_IRQ_STAT, 8'h03);
    chk(OFS_CAUSE, 8'h01);
    put(OFS_CMD, 8'h06);
    chk(OFS_CTRL, 8'h09);
    put(OFS_CMD, 8'h05);
    put(OFS_CTRL, 8'h18);
    put(OFS_CTRL, 8'h00);
    chk(OFS_CTRL, 8'h08);
    put(OFS_CAUSE, 8'h00);
    chk(OFS_CAUSE, 8'h00);
    put(OFS_CTRL, 8'h18);
    put(OFS_CTRL, 8'h00);
    chk(OFS_CTRL, 8'h00);
    put(OFS_CMD, 8'h08);
    put(OFS_CTRL, 8'h40);
    chk(OFS_CTRL, 8'h08);
    end_of_test;
  end
endmodule // watchdog_timer_with_interrupt_mode_test
`default_nettype wire
